/* hw/ssp_params.svh */
// Constants of the serial programming port: codes, keys, counts, offsets.
// Included by the port logic; holds definitions only.
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// ==========================================================
// Serial protocol
`define SSP_CODE_BITS      3'd4
`define SSP_INSTR_BITS     5'd24
`define SSP_FIRST_EXTRA    4'd5
`define SSP_FORCED_BITS    5'd9
`define SSP_READ_WAIT      4'd8
`define SSP_READ_BITS      5'd16
`define SSP_KEY_BITS       6'd32
`define SSP_CODE_EXEC      4'h0
`define SSP_CODE_READOUT   4'h1
`define SSP_ENTRY_KEY      32'h4D434851
`define SSP_NOP_INSTR      24'h000000

// ==========================================================
// Timing
`define SSP_CLK_NS         4
`define SSP_P7_NS          1000
`define SSP_P7_CYC         ((`SSP_P7_NS + `SSP_CLK_NS - 1) / `SSP_CLK_NS)

// ==========================================================
// Flash control registers
`define SSP_CTRL_OFS       4'h0
`define SSP_KEY_OFS        4'h4
`define SSP_CTRL_RST       16'h0000
`define SSP_WR_BIT         15
`define SSP_UNLOCK_1       8'h55
`define SSP_UNLOCK_2       8'hAA
`define SSP_OP_BULK        15'h407F
`define SSP_OP_EXEC_ERASE  15'h4072
`define SSP_OP_BOOT_GEN    15'h406E
`define SSP_OP_GEN_CFG     15'h404E
`define SSP_OP_GEN_ONLY    15'h4042
`define SSP_OP_ROW_ERASE   15'h4071
`define SSP_OP_CFG_WRITE   15'h4008
`define SSP_OP_ROW_WRITE   15'h4001

`endif

/* hw/ssp_pkg.sv */
// Types shared by the serial programming port.
// No dependencies.
package ssp_pkg;
   typedef enum logic [3:0] {
      ST_IDLE, ST_MASTER_CLEAR_PIN_HI, ST_KEY, ST_KEY_DONE, ST_LOCKOUT, ST_ENTRY_WAIT,
      ST_FORCED, ST_INSTR, ST_EXEC, ST_CODE, ST_RD_WAIT, ST_RD_OUT, ST_RD_HOLD
   } ssp_state_t;

   typedef enum logic [3:0] {
      OP_NONE, OP_BULK, OP_EXEC_ERASE, OP_BOOT_GEN, OP_GEN_CFG,
      OP_GEN_ONLY, OP_ROW_ERASE, OP_CFG_WRITE, OP_ROW_WRITE
   } ssp_flash_op_t;
endpackage

/* hw/ssp_sync2.sv */
// Two-stage synchroniser for asynchronous pin levels.
// Assumes a free-running clk and synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module ssp_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] q_ff;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         meta_ff <= '0;
         q_ff    <= '0;
      end
      else
      begin
         meta_ff <= d;
         q_ff    <= meta_ff;
      end
   end

   assign q = q_ff;
endmodule
`default_nettype wire

/* hw/ssp_port.sv */
// Serial programming port: entry key, control-code sequencer, readout
// shifter and flash operation control.
// Assumes pins are asynchronous to ref_clk and the clock pin runs well
// below ref_clk/4 so every edge is seen.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "ssp_params.svh"

module ssp_port #(
   parameter int POST_ENTRY_WAIT_CYC = `SSP_P7_CYC
) (
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire logic                  prog_clock_pin,
   input  wire logic                  prog_data_pin_in,
   output logic                       prog_data_pin_out,
   output logic                       prog_data_pin_oe_n,
   input  wire logic                  master_clear_pin,
   input  wire logic [15:0]           visible_output_register,
   output logic                       prog_mode_active,
   output logic                       unused_io_hiz,
   output logic                       cpu_step,
   output logic                       cpu_suspend,
   output logic [23:0]                instr_word,
   output logic                       instr_exec,
   input  wire logic [3:0]            reg_addr,
   input  wire logic [15:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic [15:0]                reg_rdata,
   output logic [15:0]                flash_op_control_reg,
   output ssp_pkg::ssp_flash_op_t     flash_op
);
   // ==========================================================
   // Parameter check
   if (POST_ENTRY_WAIT_CYC < 1 || POST_ENTRY_WAIT_CYC > 65535)
   begin : g_bad_wait
      $error("POST_ENTRY_WAIT_CYC out of range");
   end

   // ==========================================================
   // Pin synchronisation and clock-pin edges
   logic [2:0]          pins_s;
   logic                clk_d_ff;
   logic                clk_s;
   logic                din_s;
   logic                master_clear_pin_s;
   logic                rise;
   logic                fall;

   ssp_sync2 #(.WIDTH(3)) u_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .d       ({master_clear_pin, prog_data_pin_in, prog_clock_pin}),
      .q       (pins_s)
   );

   assign clk_s  = pins_s[0];
   assign din_s  = pins_s[1];
   assign master_clear_pin_s = pins_s[2];

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         clk_d_ff <= 1'b0;
      else
         clk_d_ff <= clk_s;
   end

   assign rise = clk_s & ~clk_d_ff;
   assign fall = ~clk_s & clk_d_ff;

   // ==========================================================
   // Sequencer
   ssp_pkg::ssp_state_t st_ff;
   logic [5:0]          cnt_ff;
   logic [15:0]         wait_ff;
   logic [31:0]         key_ff;
   logic [3:0]          code_ff;
   logic [23:0]         sh_ff;
   logic [3:0]          nxt_code;
   logic                mode_ff;

   assign nxt_code = {din_s, code_ff[3:1]};

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         st_ff   <= ssp_pkg::ST_IDLE;
         cnt_ff  <= 6'h00;
         wait_ff <= 16'h0000;
      end
      else if (mode_ff && !master_clear_pin_s)
      begin
         st_ff  <= ssp_pkg::ST_IDLE;
         cnt_ff <= 6'h00;
      end
      else
      begin
         unique case (st_ff)
            ssp_pkg::ST_IDLE:
               if (master_clear_pin_s)
                  st_ff <= ssp_pkg::ST_MASTER_CLEAR_PIN_HI;
            ssp_pkg::ST_MASTER_CLEAR_PIN_HI:
               if (!master_clear_pin_s)
               begin
                  st_ff  <= ssp_pkg::ST_KEY;
                  cnt_ff <= 6'h00;
               end
            ssp_pkg::ST_KEY:
               if (master_clear_pin_s)
                  st_ff <= ssp_pkg::ST_MASTER_CLEAR_PIN_HI;
               else if (fall)
               begin
                  cnt_ff <= cnt_ff + 6'h01;
                  if (cnt_ff == `SSP_KEY_BITS - 6'h01)
                     st_ff <= ssp_pkg::ST_KEY_DONE;
               end
            ssp_pkg::ST_KEY_DONE:
               if (master_clear_pin_s)
               begin
                  wait_ff <= 16'h0000;
                  if (key_ff == `SSP_ENTRY_KEY)
                     st_ff <= ssp_pkg::ST_ENTRY_WAIT;
                  else
                     st_ff <= ssp_pkg::ST_LOCKOUT;
               end
            ssp_pkg::ST_LOCKOUT:
               if (!master_clear_pin_s)
                  st_ff <= ssp_pkg::ST_IDLE;
            ssp_pkg::ST_ENTRY_WAIT:
            begin
               // Pin activity here is deliberately not looked at
               wait_ff <= wait_ff + 16'h0001;
               if (wait_ff == 16'(POST_ENTRY_WAIT_CYC - 1))
               begin
                  st_ff  <= ssp_pkg::ST_FORCED;
                  cnt_ff <= 6'h00;
               end
            end
            ssp_pkg::ST_FORCED:
               // Forced code plus the extra first-word clocks
               if (fall)
               begin
                  cnt_ff <= cnt_ff + 6'h01;
                  if (cnt_ff[4:0] == `SSP_FORCED_BITS - 5'd1)
                  begin
                     st_ff  <= ssp_pkg::ST_INSTR;
                     cnt_ff <= 6'h00;
                  end
               end
            ssp_pkg::ST_INSTR:
               if (fall)
               begin
                  cnt_ff <= cnt_ff + 6'h01;
                  if (cnt_ff[4:0] == `SSP_INSTR_BITS - 5'd1)
                  begin
                     st_ff  <= ssp_pkg::ST_EXEC;
                     cnt_ff <= 6'h00;
                  end
               end
            ssp_pkg::ST_EXEC, ssp_pkg::ST_CODE:
               if (fall)
               begin
                  cnt_ff <= cnt_ff + 6'h01;
                  if (cnt_ff[2:0] == `SSP_CODE_BITS - 3'd1)
                  begin
                     cnt_ff <= 6'h00;
                     // Reserved codes are dropped; another code follows
                     if (nxt_code == `SSP_CODE_EXEC)
                        st_ff <= ssp_pkg::ST_INSTR;
                     else if (nxt_code == `SSP_CODE_READOUT)
                        st_ff <= ssp_pkg::ST_RD_WAIT;
                     else
                        st_ff <= ssp_pkg::ST_CODE;
                  end
               end
            ssp_pkg::ST_RD_WAIT:
               if (fall)
               begin
                  cnt_ff <= cnt_ff + 6'h01;
                  if (cnt_ff[3:0] == `SSP_READ_WAIT - 4'd1)
                  begin
                     st_ff  <= ssp_pkg::ST_RD_OUT;
                     cnt_ff <= 6'h00;
                  end
               end
            ssp_pkg::ST_RD_OUT:
               if (fall)
               begin
                  cnt_ff <= cnt_ff + 6'h01;
                  if (cnt_ff[4:0] == `SSP_READ_BITS - 5'd1)
                  begin
                     st_ff  <= ssp_pkg::ST_RD_HOLD;
                     cnt_ff <= 6'h00;
                  end
               end
            ssp_pkg::ST_RD_HOLD:
               if (rise)
                  st_ff <= ssp_pkg::ST_CODE;
         endcase
      end
   end

   // Key arrives MSB first, codes and instructions LSB first
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         key_ff  <= 32'h00000000;
         code_ff <= 4'h0;
      end
      else if (fall)
      begin
         if (st_ff == ssp_pkg::ST_KEY)
            key_ff <= {key_ff[30:0], din_s};
         if (st_ff == ssp_pkg::ST_EXEC || st_ff == ssp_pkg::ST_CODE)
            code_ff <= nxt_code;
      end
   end

   // ==========================================================
   // Instruction and readout shifting
   logic [23:0]         instr_ff;
   logic                exec_ff;
   logic                dout_ff;
   logic                oe_n_ff;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         sh_ff    <= 24'h000000;
         instr_ff <= `SSP_NOP_INSTR;
         exec_ff  <= 1'b0;
      end
      else
      begin
         exec_ff <= 1'b0;
         if (st_ff == ssp_pkg::ST_ENTRY_WAIT &&
             wait_ff == 16'(POST_ENTRY_WAIT_CYC - 1))
         begin
            instr_ff <= `SSP_NOP_INSTR;
            exec_ff  <= 1'b1;
         end
         else if (fall && st_ff == ssp_pkg::ST_INSTR)
         begin
            sh_ff <= {din_s, sh_ff[23:1]};
            if (cnt_ff[4:0] == `SSP_INSTR_BITS - 5'd1)
            begin
               instr_ff <= {din_s, sh_ff[23:1]};
               exec_ff  <= 1'b1;
            end
         end
         else if (fall && st_ff == ssp_pkg::ST_RD_WAIT &&
                  cnt_ff[3:0] == `SSP_READ_WAIT - 4'd1)
            sh_ff <= {8'h00, visible_output_register};
         else if (rise && st_ff == ssp_pkg::ST_RD_OUT)
            sh_ff <= {1'b0, sh_ff[23:1]};
      end
   end

   // Pin is turned around only by the readout states
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         dout_ff <= 1'b0;
         oe_n_ff <= 1'b1;
      end
      else if (mode_ff && !master_clear_pin_s)
         // Leaving the mode mid-readout must not leave the pin driven
         oe_n_ff <= 1'b1;
      else if (rise && st_ff == ssp_pkg::ST_RD_OUT)
      begin
         dout_ff <= sh_ff[0];
         oe_n_ff <= 1'b0;
      end
      else if ((rise && st_ff == ssp_pkg::ST_RD_HOLD) ||
               (st_ff != ssp_pkg::ST_RD_OUT && st_ff != ssp_pkg::ST_RD_HOLD))
         oe_n_ff <= 1'b1;
   end

   // ==========================================================
   // Mode and processor control
   logic                step_ff;
   logic                susp_ff;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         mode_ff <= 1'b0;
         step_ff <= 1'b0;
         susp_ff <= 1'b1;
      end
      else
      begin
         mode_ff <= st_ff inside {ssp_pkg::ST_FORCED, ssp_pkg::ST_INSTR,
                                  ssp_pkg::ST_EXEC, ssp_pkg::ST_CODE,
                                  ssp_pkg::ST_RD_WAIT, ssp_pkg::ST_RD_OUT,
                                  ssp_pkg::ST_RD_HOLD, ssp_pkg::ST_ENTRY_WAIT};
         step_ff <= mode_ff && rise;
         susp_ff <= (st_ff != ssp_pkg::ST_EXEC);
      end
   end

   // ==========================================================
   // Flash control and unlock registers
   logic [15:0]            ctrl_ff;
   logic                   half_ff;
   logic                   armed_ff;
   logic [15:0]            rdata_ff;
   ssp_pkg::ssp_flash_op_t op_ff;
   logic                   ctrl_wr;
   logic                   key_wr;

   assign ctrl_wr = reg_wr && reg_addr == `SSP_CTRL_OFS;
   assign key_wr  = reg_wr && reg_addr == `SSP_KEY_OFS;

   function automatic ssp_pkg::ssp_flash_op_t op_decode(input logic [14:0] v);
      unique case (v)
         `SSP_OP_BULK:       op_decode = ssp_pkg::OP_BULK;
         `SSP_OP_EXEC_ERASE: op_decode = ssp_pkg::OP_EXEC_ERASE;
         `SSP_OP_BOOT_GEN:   op_decode = ssp_pkg::OP_BOOT_GEN;
         `SSP_OP_GEN_CFG:    op_decode = ssp_pkg::OP_GEN_CFG;
         `SSP_OP_GEN_ONLY:   op_decode = ssp_pkg::OP_GEN_ONLY;
         `SSP_OP_ROW_ERASE:  op_decode = ssp_pkg::OP_ROW_ERASE;
         `SSP_OP_CFG_WRITE:  op_decode = ssp_pkg::OP_CFG_WRITE;
         `SSP_OP_ROW_WRITE:  op_decode = ssp_pkg::OP_ROW_WRITE;
         default:            op_decode = ssp_pkg::OP_NONE;
      endcase
   endfunction

   // Any key or control register write other than the exact pair breaks the unlock
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         half_ff  <= 1'b0;
         armed_ff <= 1'b0;
      end
      else if (key_wr)
      begin
         half_ff  <= reg_wdata[7:0] == `SSP_UNLOCK_1;
         armed_ff <= half_ff && reg_wdata[7:0] == `SSP_UNLOCK_2;
      end
      else if (ctrl_wr)
      begin
         half_ff  <= 1'b0;
         armed_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ctrl_ff <= `SSP_CTRL_RST;
         op_ff   <= ssp_pkg::OP_NONE;
      end
      else if (ctrl_wr)
      begin
         ctrl_ff[14:0] <= reg_wdata[14:0];
         // Clearing ends a cycle at any time; setting needs the key
         if (!reg_wdata[`SSP_WR_BIT] || armed_ff || ctrl_ff[`SSP_WR_BIT])
            ctrl_ff[`SSP_WR_BIT] <= reg_wdata[`SSP_WR_BIT];
         if (reg_wdata[`SSP_WR_BIT] && (armed_ff || ctrl_ff[`SSP_WR_BIT]))
            op_ff <= op_decode(reg_wdata[14:0]);
         else
            op_ff <= ssp_pkg::OP_NONE;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         rdata_ff <= 16'h0000;
      else if (reg_rd && reg_addr == `SSP_CTRL_OFS)
         rdata_ff <= ctrl_ff;
      else
         rdata_ff <= 16'h0000;
   end

   // ==========================================================
   // Outputs
   assign prog_data_pin_out    = dout_ff;
   assign prog_data_pin_oe_n   = oe_n_ff;
   assign prog_mode_active     = mode_ff;
   assign unused_io_hiz        = mode_ff;
   assign cpu_step             = step_ff;
   assign cpu_suspend          = susp_ff;
   assign instr_word           = instr_ff;
   assign instr_exec           = exec_ff;
   assign reg_rdata            = rdata_ff;
   assign flash_op_control_reg = ctrl_ff;
   assign flash_op             = op_ff;

   // ==========================================================
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_pin_dir_read: assert property (
      !oe_n_ff |-> st_ff inside {ssp_pkg::ST_RD_OUT, ssp_pkg::ST_RD_HOLD})
      else $error("data pin driven outside readout");
   a_hold_release: assert property (
      st_ff == ssp_pkg::ST_RD_HOLD && rise && !(mode_ff && !master_clear_pin_s)
      |=> oe_n_ff && st_ff == ssp_pkg::ST_CODE)
      else $error("data pin not released at rise");
   a_instr_exec: assert property (
      st_ff == ssp_pkg::ST_INSTR && fall && cnt_ff == 6'd23 && master_clear_pin_s
      |=> exec_ff && st_ff == ssp_pkg::ST_EXEC ##1 !susp_ff)
      else $error("instruction not executed after 24 bits");
   a_read_wait: assert property (
      st_ff == ssp_pkg::ST_RD_WAIT && fall && cnt_ff == 6'd7 && master_clear_pin_s
      |=> st_ff == ssp_pkg::ST_RD_OUT)
      else $error("readout wait not eight cycles");
   a_read_bits: assert property (
      st_ff == ssp_pkg::ST_RD_OUT && fall && cnt_ff == 6'd15 && master_clear_pin_s
      |=> st_ff == ssp_pkg::ST_RD_HOLD)
      else $error("readout not sixteen bits");
   a_key_exact: assert property (
      st_ff == ssp_pkg::ST_KEY_DONE && master_clear_pin_s && key_ff != 32'h4D434851
      |=> st_ff == ssp_pkg::ST_LOCKOUT ##1 !mode_ff)
      else $error("mode entered on wrong key");
   a_wr_locked: assert property (
      ctrl_wr && reg_wdata[15] && !armed_ff && !ctrl_ff[15]
      |=> !ctrl_ff[15] && op_ff == ssp_pkg::OP_NONE)
      else $error("trigger set without unlock");
   a_bulk_decode: assert property (
      ctrl_wr && armed_ff && reg_wdata == 16'hC07F
      |=> ctrl_ff[15] && op_ff == ssp_pkg::OP_BULK)
      else $error("bulk erase not started");
   a_entry_quiet: assert property (
      st_ff == ssp_pkg::ST_ENTRY_WAIT && wait_ff == 16'h0000 |=> $stable(sh_ff))
      else $error("data taken during entry wait");
   a_step_mode: assert property (
      step_ff |-> $past(mode_ff) && $past(rise))
      else $error("processor stepped outside mode");
endmodule
`default_nettype wire

/* verification/ssp_prog_model.sv */
// Behavioural programmer on the far side of the serial programming port.
// Assumes the bench resolves the data wire from both drivers.
`timescale 1ns/100ps
`default_nettype none
module ssp_prog_model (
   input  wire logic ref_clk,
   input  wire logic data_sense,
   output logic      clk_pin,
   output logic      data_drv,
   output logic      data_en,
   output logic      clear_pin
);
   // ==========================================================
   // Pin timing: 64 ns clock pin, 16 bench cycles per bit
   initial
   begin
      clk_pin = 1'b0;
      data_drv = 1'b0;
      data_en = 1'b0;
      clear_pin = 1'b0;
   end

   task automatic half();
      repeat (8) @(posedge ref_clk);
   endtask

   // Clock pin idles low between frames, so every call is one whole bit
   task automatic bit_cycle(input logic d, input logic en, output logic q);
      clk_pin <= 1'b1;
      data_drv <= d; // launch on rise
      data_en <= en;
      half();
      q = data_sense; // capture at fall
      clk_pin <= 1'b0;
      half();
   endtask

   task automatic send(input logic [31:0] v, input int n, input logic msb);
      logic q;
      for (int i = 0; i < n; i++)
         bit_cycle(msb ? v[n-1-i] : v[i], 1'b1, q);
   endtask

   // ==========================================================
   // Mode entry and readout
   task automatic enter(input logic [31:0] key);
      clear_pin <= 1'b1;
      half();
      clear_pin <= 1'b0;
      repeat (2) half(); // key setup interval
      send(key, 32, 1'b1);
      clear_pin <= 1'b1;
   endtask

   task automatic leave();
      clear_pin <= 1'b0;
      repeat (2) half();
   endtask

   // Pin released for the idle and data clocks; device drives the wire only for the data clocks
   task automatic readout(output logic [15:0] v);
      logic q;
      for (int i = 0; i < 8; i++)
         bit_cycle(1'b0, 1'b0, q);
      for (int i = 0; i < 16; i++)
      begin
         bit_cycle(1'b0, 1'b0, q);
         v[i] = q;
      end
   endtask
endmodule
`default_nettype wire

/* verification/serial_program_port_tb.sv */
// Bench for the serial programming port: pin protocol through the
// programmer model, flash control through the register port.
// Assumes the design and the model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "ssp_params.svh"
module serial_program_port_tb;
   localparam int          wait_cyc = 20;
   localparam logic [14:0] flash_codes [8] = '{`SSP_OP_BULK, `SSP_OP_EXEC_ERASE,
      `SSP_OP_BOOT_GEN, `SSP_OP_GEN_CFG, `SSP_OP_GEN_ONLY, `SSP_OP_ROW_ERASE,
      `SSP_OP_CFG_WRITE, `SSP_OP_ROW_WRITE};
   logic                   ref_clk = 1'b0, rst = 1'b1, rd_q = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic                   clk_pin, drv, drv_en, clear_pin, data_wire, dout, oe_n;
   logic                   mode, hiz, step, suspend, iexec;
   logic [3:0]             reg_addr = 4'h0;
   logic [15:0]            reg_wdata = 16'h0000, visible = 16'h0000, reg_rdata, ctrl, seen;
   logic [23:0]            iword, w;
   logic [23:0]            rd_exp[$], ex_exp[$];
   ssp_pkg::ssp_flash_op_t flash_op;
   int                     bad_count = 0, tests_run = 0, steps = 0, s0;

   initial
   begin
      forever #2 ref_clk = ~ref_clk;
   end

   // Data wire has a pull-up when neither side drives it
   assign data_wire = !oe_n ? dout : (drv_en ? drv : 1'b1);

   ssp_prog_model pm_u (.ref_clk(ref_clk), .data_sense(data_wire), .clk_pin(clk_pin),
      .data_drv(drv), .data_en(drv_en), .clear_pin(clear_pin));

   ssp_port #(.POST_ENTRY_WAIT_CYC(wait_cyc)) dut_u (.ref_clk(ref_clk), .rst(rst),
      .prog_clock_pin(clk_pin), .prog_data_pin_in(data_wire), .prog_data_pin_out(dout),
      .prog_data_pin_oe_n(oe_n), .master_clear_pin(clear_pin),
      .visible_output_register(visible), .prog_mode_active(mode), .unused_io_hiz(hiz),
      .cpu_step(step), .cpu_suspend(suspend), .instr_word(iword), .instr_exec(iexec),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .flash_op_control_reg(ctrl), .flash_op(flash_op));

   // ==========================================================
   // Result checking
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // An empty queue yields X, so an unexpected result always mismatches
   always @(posedge ref_clk)
   begin
      rd_q <= reg_rd;
      if (step)
         steps <= steps + 1;
      if (rd_q)
         check("reg_rdata", rd_exp.size() ? rd_exp.pop_front() : 24'hXXXXXX,
               {8'h00, reg_rdata});
      if (iexec)
         check("instr_word", ex_exp.size() ? ex_exp.pop_front() : 24'hXXXXXX,
               iword);
   end

   // ==========================================================
   // Register port
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [23:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      rd_exp.push_back(exp);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask

   task automatic conclude();
      if (bad_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (100000) @(posedge ref_clk);
      bad_count++;
      conclude();
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      void'($urandom(32'h974D8FAE));
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      pm_u.enter(~`SSP_ENTRY_KEY);
      repeat (wait_cyc + 8) @(posedge ref_clk);
      check("prog_mode_active", 24'h0, {23'h0, mode});
      pm_u.leave();
      ex_exp.push_back(`SSP_NOP_INSTR);
      pm_u.enter(`SSP_ENTRY_KEY);
      repeat (wait_cyc + 8) @(posedge ref_clk);
      check("unused_io_hiz", 24'h1, {23'h0, hiz});
      pm_u.send(32'h0, 9, 1'b0); // forced code and five extra clocks
      check("cpu_suspend", 24'h1, {23'h0, suspend});
      visible <= 16'($urandom);
      for (int k = 0; k < 4; k++)
      begin
         w = k[0] ? `SSP_NOP_INSTR : 24'($urandom); // filler after each word
         ex_exp.push_back(w);
         s0 = steps;
         pm_u.send({8'h00, w}, 24, 1'b0);
         pm_u.send((k == 3) ? 32'h1 : 32'h0, 1, 1'b0);
         check("cpu_suspend", 24'h0, {23'h0, suspend});
         pm_u.send(32'h0, 3, 1'b0);
         check("cpu_steps", 24'd28, 24'(steps - s0));
      end
      pm_u.readout(seen);
      check("readout", {8'h00, visible}, {8'h00, seen});
      check("data_pin_oe_n", 24'h0, {23'h0, oe_n});
      pm_u.send(32'hA, 4, 1'b0); // reserved code, skipped
      check("data_pin_oe_n", 24'h1, {23'h0, oe_n});
      w = 24'($urandom);
      ex_exp.push_back(w);
      pm_u.send(32'h0, 4, 1'b0);
      pm_u.send({8'h00, w}, 24, 1'b0);
      pm_u.send(32'h0, 4, 1'b0);
      pm_u.leave();
      rd(`SSP_KEY_OFS, 24'h0);
      rd(4'h8, 24'h0);
      wr(`SSP_KEY_OFS, 16'h00AA);
      wr(`SSP_KEY_OFS, 16'h0055);
      wr(`SSP_CTRL_OFS, {1'b1, flash_codes[0]});
      rd(`SSP_CTRL_OFS, {9'h000, flash_codes[0]});
      check("flash_op", 24'h0, 24'(flash_op));
      for (int i = 0; i < 8; i++)
      begin
         wr(`SSP_KEY_OFS, 16'h0055);
         wr(`SSP_KEY_OFS, 16'h00AA);
         wr(`SSP_CTRL_OFS, {1'b1, flash_codes[i]});
         rd(`SSP_CTRL_OFS, {8'h00, 1'b1, flash_codes[i]});
         check("flash_op_control_reg", {9'h001, flash_codes[i]}, {8'h00, ctrl});
         check("flash_op", 24'(i + 1), 24'(flash_op));
         repeat (8) @(posedge ref_clk); // cycle timed from outside, scaled down
         wr(`SSP_CTRL_OFS, {1'b0, flash_codes[i]});
         rd(`SSP_CTRL_OFS, {9'h000, flash_codes[i]});
         check("flash_op", 24'h0, 24'(flash_op));
      end
      repeat (4) @(posedge ref_clk);
      conclude();
   end
endmodule
`default_nettype wire
